// >>> core/rxf_params.svh
`ifndef RXF_PARAMS_SVH
`define RXF_PARAMS_SVH

// register indices (word offsets) and reset values
`define RX_FILTER_CONFIG_IDX        12'h134
`define RX_FILTER_STATUS_IDX     12'h135
`define RXF_IRQ_MASK_IDX   12'h136
`define RXF_IRQ_STAT_IDX   12'h137
`define RX_FILTER_CONFIG_RST        16'h1000
`define RX_FILTER_STATUS_RST     16'h0000
`define RXF_IRQ_MASK_RST   16'h0000

// config field positions
`define CFG_MAGIC_BIT      0
`define CFG_PATTERN_BIT    1
`define CFG_BCAST_BIT      2
`define CFG_UCAST_BIT      4
`define CFG_FEATURE_BIT    7
`define CFG_STYLE_BIT      8
`define CFG_LEN_LO         9
`define CFG_LEN_HI         10
`define CFG_CLEAR_BIT      11

// status field positions
`define ST_MAGIC_BIT       0
`define ST_PATTERN_BIT     1
`define ST_BCAST_BIT       2
`define ST_UCAST_BIT       4
`define ST_CRC_BIT         6
`define ST_SFD_BIT         7

// wake pulse lengths in clock cycles
`define WAKE_LEN_0         7'd8
`define WAKE_LEN_1         7'd16
`define WAKE_LEN_2         7'd32
`define WAKE_LEN_3         7'd64

// axi responses
`define AXI_RESP_OKAY      2'h0
`define AXI_RESP_SLVERR    2'h2

`endif

// >>> core/rxf_pkg.sv
package rxf_pkg;

  typedef struct packed {
    logic unicast;
    logic broadcast;
    logic pattern;
    logic magic;
    logic bad_crc;
    logic delimiter_error;
  } rx_event_s;

  typedef enum logic [2:0] {
    WK_IDLE  = 3'b001,
    WK_PULSE = 3'b010,
    WK_LEVEL = 3'b100
  } wake_state_e;

endpackage

// >>> core/wake_on_lan_rx_filter.sv
// Chosen here: register access over AXI4-Lite.
`timescale 1ns/1ps
`default_nettype none
`include "rxf_params.svh"

module wake_on_lan_rx_filter (
  input  wire logic              aclk,
  input  wire logic              aresetn,
  input  wire logic              clk_en,
  input  wire rxf_pkg::rx_event_s rx_event,
  input  wire logic [31:0]       s_axi_awaddr,
  input  wire logic              s_axi_awvalid,
  output logic                   s_axi_awready,
  input  wire logic [31:0]       s_axi_wdata,
  input  wire logic [3:0]        s_axi_wstrb,
  input  wire logic              s_axi_wvalid,
  output logic                   s_axi_wready,
  output logic [1:0]             s_axi_bresp,
  output logic                   s_axi_bvalid,
  input  wire logic              s_axi_bready,
  input  wire logic [31:0]       s_axi_araddr,
  input  wire logic              s_axi_arvalid,
  output logic                   s_axi_arready,
  output logic [31:0]            s_axi_rdata,
  output logic [1:0]             s_axi_rresp,
  output logic                   s_axi_rvalid,
  input  wire logic              s_axi_rready,
  output logic                   wake_out,
  output logic                   irq
);
  import rxf_pkg::*;

  localparam logic [13:0] CFG_ADDR  = {`RX_FILTER_CONFIG_IDX, 2'b00};
  localparam logic [13:0] STAT_ADDR = {`RX_FILTER_STATUS_IDX, 2'b00};
  localparam logic [13:0] MASK_ADDR = {`RXF_IRQ_MASK_IDX, 2'b00};
  localparam logic [13:0] IRQS_ADDR = {`RXF_IRQ_STAT_IDX, 2'b00};
  localparam logic [15:0] CFG_WMASK = 16'hF7F7;
  localparam logic [15:0] EVT_MASK  = 16'h00D7;
  localparam logic [15:0] WAKE_MASK = 16'h0017;

  logic [15:0] cfg_r;
  logic [15:0] status_r;
  logic [15:0] status_nxt;
  logic [15:0] irq_stat_r;
  logic [15:0] irq_mask_r;
  logic [15:0] evt_vec;
  logic [15:0] wake_hits;

  logic        aw_held_r;
  logic [13:0] aw_addr_r;
  logic        w_held_r;
  logic [31:0] w_data_r;
  logic [3:0]  w_strb_r;
  logic        bvalid_r;
  logic [1:0]  bresp_r;
  logic        rvalid_r;
  logic [31:0] rdata_r;
  logic [1:0]  rresp_r;

  logic        do_write;
  logic        do_read;
  logic        status_read;
  logic        clear_write;

  function automatic logic mapped(input logic [31:0] addr);
    mapped = (addr[31:14] == 18'h00000) &&
             (addr[13:0] == CFG_ADDR  || addr[13:0] == STAT_ADDR ||
              addr[13:0] == MASK_ADDR || addr[13:0] == IRQS_ADDR);
  endfunction

  function automatic logic [15:0] merge16(input logic [15:0] old,
                                          input logic [31:0] data,
                                          input logic [3:0]  strb);
    merge16[7:0]  = strb[0] ? data[7:0]  : old[7:0];
    merge16[15:8] = strb[1] ? data[15:8] : old[15:8];
  endfunction

  // event vector in status layout
  always_comb begin
    evt_vec                  = 16'h0000;
    evt_vec[`ST_MAGIC_BIT]   = rx_event.magic;
    evt_vec[`ST_PATTERN_BIT] = rx_event.pattern;
    evt_vec[`ST_BCAST_BIT]   = rx_event.broadcast;
    evt_vec[`ST_UCAST_BIT]   = rx_event.unicast;
    evt_vec[`ST_CRC_BIT]     = rx_event.bad_crc;
    evt_vec[`ST_SFD_BIT]     = rx_event.delimiter_error;
  end

  // matches that are both seen and enabled
  assign wake_hits = evt_vec & cfg_r & WAKE_MASK;

  // ---------------- axi write channel ----------------
  assign s_axi_awready = !aw_held_r && !bvalid_r;
  assign s_axi_wready  = !w_held_r && !bvalid_r;
  assign s_axi_bvalid  = bvalid_r;
  assign s_axi_bresp   = bresp_r;
  assign do_write      = clk_en && aw_held_r && w_held_r && !bvalid_r;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_held_r <= 1'b0;
      aw_addr_r <= 14'h0000;
    end else if (clk_en) begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_held_r <= 1'b1;
        aw_addr_r <= mapped(s_axi_awaddr) ? s_axi_awaddr[13:0] : 14'h3FFF;
      end else if (do_write) begin
        aw_held_r <= 1'b0;
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      w_held_r <= 1'b0;
      w_data_r <= 32'h00000000;
      w_strb_r <= 4'h0;
    end else if (clk_en) begin
      if (s_axi_wvalid && s_axi_wready) begin
        w_held_r <= 1'b1;
        w_data_r <= s_axi_wdata;
        w_strb_r <= s_axi_wstrb;
      end else if (do_write) begin
        w_held_r <= 1'b0;
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      bvalid_r <= 1'b0;
      bresp_r  <= `AXI_RESP_OKAY;
    end else if (clk_en) begin
      if (do_write) begin
        bvalid_r <= 1'b1;
        bresp_r  <= (aw_addr_r == 14'h3FFF) ? `AXI_RESP_SLVERR
                                            : `AXI_RESP_OKAY;
      end else if (s_axi_bready) begin
        bvalid_r <= 1'b0;
      end
    end
  end

  // a write touching byte 1 of the config word with bit 11 set hits the clear bit
  assign clear_write = do_write && aw_addr_r == CFG_ADDR && w_strb_r[1] &&
                       w_data_r[`CFG_CLEAR_BIT];

  // config register; clear bit is self-clearing
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cfg_r <= `RX_FILTER_CONFIG_RST;
    end else if (clk_en) begin
      if (do_write && aw_addr_r == CFG_ADDR) begin
        cfg_r <= merge16(cfg_r, w_data_r, w_strb_r) & CFG_WMASK;
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      irq_mask_r <= `RXF_IRQ_MASK_RST;
    end else if (clk_en) begin
      if (do_write && aw_addr_r == MASK_ADDR) begin
        irq_mask_r <= merge16(irq_mask_r, w_data_r, w_strb_r) & WAKE_MASK;
      end
    end
  end

  // interrupt status: sticky, write one to clear, set wins
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      irq_stat_r <= 16'h0000;
    end else if (clk_en) begin
      if (do_write && aw_addr_r == IRQS_ADDR) begin
        irq_stat_r <= (irq_stat_r & ~merge16(16'h0000, w_data_r, w_strb_r))
                      | wake_hits;
      end else begin
        irq_stat_r <= irq_stat_r | wake_hits;
      end
    end
  end

  assign irq = |(irq_stat_r & irq_mask_r);

  // ---------------- axi read channel ----------------
  assign s_axi_arready = !rvalid_r;
  assign s_axi_rvalid  = rvalid_r;
  assign s_axi_rdata   = rdata_r;
  assign s_axi_rresp   = rresp_r;
  assign do_read       = clk_en && s_axi_arvalid && !rvalid_r;
  assign status_read   = do_read && s_axi_araddr[31:14] == 18'h00000 &&
                         s_axi_araddr[13:0] == STAT_ADDR;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rvalid_r <= 1'b0;
      rdata_r  <= 32'h00000000;
      rresp_r  <= `AXI_RESP_OKAY;
    end else if (clk_en) begin
      if (do_read) begin
        rvalid_r <= 1'b1;
        rresp_r  <= mapped(s_axi_araddr) ? `AXI_RESP_OKAY
                                         : `AXI_RESP_SLVERR;
        case (s_axi_araddr[13:0])
          CFG_ADDR:  rdata_r <= {16'h0000, cfg_r};
          STAT_ADDR: rdata_r <= {16'h0000, status_r};
          MASK_ADDR: rdata_r <= {16'h0000, irq_mask_r};
          IRQS_ADDR: rdata_r <= {16'h0000, irq_stat_r};
          default:   rdata_r <= 32'h00000000;
        endcase
        if (!mapped(s_axi_araddr)) begin
          rdata_r <= 32'h00000000;
        end
      end else if (s_axi_rready) begin
        rvalid_r <= 1'b0;
      end
    end
  end

  // status flags: set on every event, read clears, set wins
  always_comb begin
    status_nxt = status_read ? 16'h0000 : status_r;
    status_nxt = (status_nxt | evt_vec) & EVT_MASK;
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      status_r <= `RX_FILTER_STATUS_RST;
    end else if (clk_en) begin
      status_r <= status_nxt;
    end
  end

  // ---------------- wake output ----------------
  wake_output_gen u_wake (
    .aclk        (aclk),
    .aresetn     (aresetn),
    .clk_en      (clk_en),
    .trigger     (|wake_hits),
    .level_style (cfg_r[`CFG_STYLE_BIT]),
    .pulse_len   (cfg_r[`CFG_LEN_HI:`CFG_LEN_LO]),
    .level_clear (clear_write),
    .wake_out    (wake_out)
  );

endmodule
`default_nettype wire

// >>> core/wake_output_gen.sv
`timescale 1ns/1ps
`default_nettype none
`include "rxf_params.svh"

module wake_output_gen (
  input  wire logic       aclk,
  input  wire logic       aresetn,
  input  wire logic       clk_en,
  input  wire logic       trigger,
  input  wire logic       level_style,
  input  wire logic [1:0] pulse_len,
  input  wire logic       level_clear,
  output logic            wake_out
);
  import rxf_pkg::*;

  wake_state_e state_r;
  logic [6:0]  count_r;

  function automatic logic [6:0] len_cycles(input logic [1:0] code);
    case (code)
      2'h0:    len_cycles = `WAKE_LEN_0;
      2'h1:    len_cycles = `WAKE_LEN_1;
      2'h2:    len_cycles = `WAKE_LEN_2;
      default: len_cycles = `WAKE_LEN_3;
    endcase
  endfunction

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      state_r <= WK_IDLE;
      count_r <= 7'h00;
    end else if (clk_en) begin
      case (state_r)
        WK_IDLE: begin
          if (trigger && level_style) begin
            state_r <= WK_LEVEL;
          end else if (trigger) begin
            state_r <= WK_PULSE;
            count_r <= len_cycles(pulse_len) - 7'h01;
          end
        end
        WK_PULSE: begin
          if (count_r == 7'h00) begin
            state_r <= WK_IDLE;
          end else begin
            count_r <= count_r - 7'h01;
          end
        end
        WK_LEVEL: begin
          if (level_clear) begin
            state_r <= WK_IDLE;
          end
        end
        default: state_r <= WK_IDLE;
      endcase
    end
  end

  assign wake_out = (state_r != WK_IDLE);

endmodule
`default_nettype wire

// >>> test/rxf_assertions.sv
`timescale 1ns/1ps
`default_nettype none
`include "rxf_params.svh"
module rxf_assertions (
  input wire logic               aclk,
  input wire logic               aresetn,
  input wire logic               clk_en,
  input wire rxf_pkg::rx_event_s rx_event,
  input wire logic               s_axi_awready,
  input wire logic               s_axi_wready,
  input wire logic [1:0]         s_axi_bresp,
  input wire logic               s_axi_bvalid,
  input wire logic               s_axi_bready,
  input wire logic               s_axi_arvalid,
  input wire logic               s_axi_arready,
  input wire logic [31:0]        s_axi_rdata,
  input wire logic [1:0]         s_axi_rresp,
  input wire logic               s_axi_rvalid,
  input wire logic               s_axi_rready,
  input wire logic               wake_out
);
  import rxf_pkg::*;
  logic hit;
  assign hit = rx_event.unicast | rx_event.broadcast | rx_event.pattern |
               rx_event.magic;
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  sequence s_rise;
    $rose(wake_out);
  endsequence
  sequence s_held;
    wake_out [*8];
  endsequence
  a_pulse_min: assert property (s_rise |-> s_held)
    else $error("wake output shorter than 8 cycles");
  a_wake_cause: assert property (s_rise |->
    $past(hit) || $past(hit, 2) || $past(hit, 3))
    else $error("wake output rose with no wake event");
  a_bresp_hold: assert property (s_axi_bvalid && !s_axi_bready |=>
    s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write response dropped early");
  a_rdata_hold: assert property (s_axi_rvalid && !s_axi_rready |=>
    s_axi_rvalid && $stable(s_axi_rdata) && $stable(s_axi_rresp))
    else $error("read response dropped early");
  a_read_answer: assert property (s_axi_arvalid && s_axi_arready && clk_en
    |=> s_axi_rvalid)
    else $error("read answer late");
  a_ar_refused: assert property (s_axi_rvalid |-> !s_axi_arready)
    else $error("read address taken while answer pending");
  a_aw_refused: assert property (s_axi_bvalid |->
    !s_axi_awready && !s_axi_wready)
    else $error("write taken while response pending");
  a_slverr_zero: assert property (s_axi_rvalid &&
    s_axi_rresp == `AXI_RESP_SLVERR |-> s_axi_rdata == 32'h0)
    else $error("error read returned data");
  a_upper_zero: assert property (s_axi_rvalid |->
    s_axi_rdata[31:16] == 16'h0)
    else $error("upper read half not zero");
endmodule
bind wake_on_lan_rx_filter rxf_assertions i_rxf_assertions (
  .aclk(aclk), .aresetn(aresetn), .clk_en(clk_en), .rx_event(rx_event),
  .s_axi_awready(s_axi_awready), .s_axi_wready(s_axi_wready),
  .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
  .s_axi_bready(s_axi_bready), .s_axi_arvalid(s_axi_arvalid),
  .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
  .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
  .s_axi_rready(s_axi_rready), .wake_out(wake_out));
`default_nettype wire

// >>> test/tb_top.sv
`timescale 1ns/1ps
`default_nettype none
`include "rxf_params.svh"
module tb_top;
  import rxf_pkg::*;
  localparam logic [31:0] CFG = {18'h0, `RX_FILTER_CONFIG_IDX, 2'h0};
  localparam logic [31:0] STA = {18'h0, `RX_FILTER_STATUS_IDX, 2'h0};
  localparam logic [31:0] MSK = {18'h0, `RXF_IRQ_MASK_IDX, 2'h0};
  localparam logic [31:0] IST = {18'h0, `RXF_IRQ_STAT_IDX, 2'h0};
  logic        aclk, aresetn, awvalid, awready, wvalid, wready, bvalid;
  logic        bready, arvalid, arready, rvalid, rready, wake_out, irq;
  logic [31:0] awaddr, wdata, araddr, rdata, rd;
  logic [3:0]  wstrb;
  logic [1:0]  bresp, rresp, rs;
  logic        ce;
  rx_event_s   rx_event;
  int          fail_count, comparisons, n;
  int          evs[6] = '{5, 4, 3, 2, 1, 0};
  int          stb[6] = '{4, 2, 1, 0, 6, 7};
  wake_on_lan_rx_filter i_wake_on_lan_rx_filter (
    .aclk(aclk), .aresetn(aresetn), .clk_en(ce), .rx_event(rx_event),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
    .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb),
    .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
    .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
    .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
    .s_axi_rready(rready), .wake_out(wake_out), .irq(irq));
  initial begin
    aclk = 1'b0;
    forever #12.5 aclk = ~aclk;
  end
  task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    comparisons++;
    if (g !== e) begin
      fail_count++;
      $display("MISMATCH %s expected %h seen %h", nm, e, g);
    end
  endtask
  task end_sim;
    $display("comparisons %0d mismatches %0d", comparisons, fail_count);
    if (fail_count == 0 && comparisons > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  // handshakes judged on settled values just before the taking edge
  task wr(input logic [31:0] a, input logic [31:0] d);
    logic ah, wh, bh;
    @(posedge aclk);
    awaddr <= a;
    wdata <= d;
    wstrb <= 4'hF;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    bh = 1'b0;
    while (!bh) begin
      @(negedge aclk);
      ah = awvalid && awready;
      wh = wvalid && wready;
      bh = bvalid;
      rs = bresp;
      @(posedge aclk);
      if (ah) awvalid <= 1'b0;
      if (wh) wvalid <= 1'b0;
    end
    bready <= 1'b0;
  endtask
  task rdr(input logic [31:0] a);
    logic ah, rh;
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    rh = 1'b0;
    while (!rh) begin
      @(negedge aclk);
      ah = arvalid && arready;
      rh = rvalid;
      rd = rdata;
      rs = rresp;
      @(posedge aclk);
      if (ah) arvalid <= 1'b0;
    end
    rready <= 1'b0;
  endtask
  task ev(input int b);
    @(posedge aclk);
    rx_event <= rx_event_s'(6'h1 << b);
    @(posedge aclk);
    rx_event <= '0;
  endtask
  task plen;
    n = 0;
    repeat (150) begin
      @(negedge aclk);
      if (wake_out === 1'b1) n++;
    end
  endtask
  initial begin
    repeat (20000) @(posedge aclk);
    fail_count++;
    end_sim;
  end
  initial begin
    aresetn = 1'b0;
    ce = 1'b1;
    rx_event = '0;
    {awvalid, wvalid, bready, arvalid, rready} = '0;
    {awaddr, wdata, araddr, wstrb} = '0;
    repeat (4) @(posedge aclk);
    aresetn <= 1'b1;
    rdr(CFG);
    chk("cfg reset", 32'h1000, rd);
    rdr(STA);
    chk("status reset", 32'h0, rd);
    chk("wake reset", 32'h0, wake_out);
    wr(CFG, 32'hFFFF);
    rdr(CFG);
    chk("cfg writable", 32'hF7F7, rd);
    wr(CFG, 32'h0);
    rdr(32'h4E0);
    chk("unmapped resp", `AXI_RESP_SLVERR, rs);
    wr(32'h4E0, 32'h1);
    chk("unmapped wresp", `AXI_RESP_SLVERR, rs);
    $display("test registers done");
    // an event seen while the clock enable is low must leave no trace
    ce <= 1'b0;
    ev(5);
    ce <= 1'b1;
    rdr(STA);
    chk("frozen event", 32'h0, rd);
    for (int i = 0; i < 6; i++) begin
      ev(evs[i]);
      rdr(STA);
      chk("status set", 32'h1 << stb[i], rd);
      rdr(STA);
      chk("status cleared", 32'h0, rd);
      chk("irq disabled", 32'h0, irq);
    end
    $display("test flags done");
    wr(MSK, 32'h17);
    for (int i = 0; i < 4; i++) begin
      wr(CFG, 32'h97 | (i << 9));
      ev(evs[i]);
      plen;
      chk("pulse length", 32'd8 << i, n);
      chk("irq raised", 32'h1, irq);
      wr(IST, 32'h1 << stb[i]);
      chk("irq cleared", 32'h0, irq);
      rdr(STA);
    end
    wr(MSK, 32'h0);
    ev(5);
    plen;
    chk("irq masked", 32'h0, irq);
    wr(MSK, 32'h17);
    chk("irq unmasked", 32'h1, irq);
    wr(IST, 32'h10);
    $display("test pulse done");
    wr(CFG, 32'h197);
    ev(2);
    plen;
    chk("level held", 32'd150, n);
    wr(CFG, 32'h997);
    @(negedge aclk);
    chk("level cleared", 32'h0, wake_out);
    rdr(CFG);
    chk("clear reads 0", 32'h197, rd);
    $display("test level done");
    end_sim;
  end
endmodule
`default_nettype wire
